// ===== rtct_pkg.sv
`default_nettype none

package rtct_pkg;

  // register addresses on the serial register port
  localparam logic [7:0] ADDR_FLAGS     = 8'h01;
  localparam logic [7:0] ADDR_TIMER_CTL = 8'h10;
  localparam logic [7:0] ADDR_TIMER_VAL = 8'h11;

  // flags register bit positions
  localparam int unsigned FLG_TICK  = 7;
  localparam int unsigned FLG_WD    = 6;
  localparam int unsigned FLG_STAMP = 5;
  localparam int unsigned FLG_ALARM = 4;
  localparam int unsigned FLG_CD    = 3;

  // timer control register field positions and reset value
  localparam int unsigned CTL_MODE_HI  = 7;
  localparam int unsigned CTL_MODE_LO  = 6;
  localparam int unsigned CTL_PULSE    = 5;
  localparam int unsigned CTL_SRC_HI   = 1;
  localparam int unsigned CTL_SRC_LO   = 0;
  localparam logic [7:0]  CTL_RESET    = 8'h03;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_CD     = 2'b01,
    MODE_WD_IRQ = 2'b10,
    MODE_WD_RST = 2'b11
  } rtct_mode_t;

  typedef enum logic [1:0] {
    SRC_4K  = 2'b00,
    SRC_64  = 2'b01,
    SRC_1   = 2'b10,
    SRC_60  = 2'b11
  } rtct_src_t;

  // reset pulse state, one-hot
  typedef enum logic [1:0] {
    RP_IDLE = 2'b01,
    RP_HOLD = 2'b10
  } rtct_rp_t;

  // clock and source rates
  localparam int unsigned CLK_HZ_DEF    = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SRC_FAST_HZ   = 4096;
  localparam int unsigned DIV_TO_64     = 64;
  localparam int unsigned DIV_TO_1      = 64;
  localparam int unsigned DIV_TO_60     = 60;

  // reset output pulse widths
  localparam int unsigned RST_SHORT_NS  = 244_000;
  localparam int unsigned RST_LONG_NS   = 15_625_000;
  localparam int unsigned RST_SHORT_CYC = RST_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_LONG_CYC  = RST_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W     = 21;

endpackage

`default_nettype wire

// ===== rtct_src_div.sv
`timescale 1ns/1ns
`default_nettype none

module rtct_src_div #(
  parameter int unsigned CLK_HZ = rtct_pkg::CLK_HZ_DEF
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic sysRstN,
  // source clock enables, one-cycle pulses
  output logic      tick4k,
  output logic      tick64,
  output logic      tick1,
  output logic      tick60
);

  localparam int unsigned DIVS [3] = '{rtct_pkg::DIV_TO_64, rtct_pkg::DIV_TO_1,
                                       rtct_pkg::DIV_TO_60};

  logic [31:0] acc_ff;
  logic [32:0] nxt_acc;
  logic        tick4k_ff;
  logic        stageIn [4];

  ////////////////////////////////////////////////////////////////////////////
  // fractional accumulator: exact 4.096 kHz average from any clock of 4096 Hz or more

  always_comb begin
    nxt_acc = {1'b0, acc_ff} + 33'(rtct_pkg::SRC_FAST_HZ);
  end

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      acc_ff    <= 32'h0000_0000;
      tick4k_ff <= 1'b0;
    end else if (nxt_acc >= 33'(CLK_HZ)) begin
      acc_ff    <= 32'(nxt_acc - 33'(CLK_HZ));
      tick4k_ff <= 1'b1;
    end else begin
      acc_ff    <= nxt_acc[31:0];
      tick4k_ff <= 1'b0;
    end
  end

  assign stageIn[0] = tick4k_ff;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler chain 4096 -> 64 -> 1 -> 1/60 Hz

  for (genvar i = 0; i < 3; i++) begin : g_stage
    logic [5:0] cnt_ff;
    logic       out_ff;
    always_ff @(posedge mclk or negedge sysRstN) begin
      if (!sysRstN) begin
        cnt_ff <= 6'h00;
        out_ff <= 1'b0;
      end else if (stageIn[i]) begin
        out_ff <= (cnt_ff == 6'(DIVS[i] - 1));
        cnt_ff <= (cnt_ff == 6'(DIVS[i] - 1)) ? 6'h00 : cnt_ff + 6'h01;
      end else begin
        out_ff <= 1'b0;
      end
    end
    assign stageIn[i+1] = out_ff;
  end

  assign tick4k = stageIn[0];
  assign tick64 = stageIn[1];
  assign tick1  = stageIn[2];
  assign tick60 = stageIn[3];

endmodule

`default_nettype wire

// ===== rtct_timer_flags.sv
`timescale 1ns/1ns
`default_nettype none

module rtct_timer_flags #(
  parameter int unsigned CLK_HZ        = rtct_pkg::CLK_HZ_DEF,
  parameter int unsigned RST_SHORT_CYC = rtct_pkg::RST_SHORT_CYC,
  parameter int unsigned RST_LONG_CYC  = rtct_pkg::RST_LONG_CYC
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // events and controls from neighbouring blocks
  input  wire logic       alarmEvt,
  input  wire logic       stampGroundEvt,
  input  wire logic       secTickEn,
  input  wire logic       minTickEn,
  input  wire logic       countdownIrqEn,
  // pins toward host
  output logic            irqN,
  output logic            rstOutN
);

  logic                      rstSync1_ff;
  logic                      rstSync2_ff;
  logic                      sysRstN;
  logic                      t4k, t64, t1, t60;
  rtct_pkg::rtct_mode_t      mode_ff;
  rtct_pkg::rtct_src_t       srcSel_ff;
  logic                      pulseSel_ff;
  logic [7:0]                nVal_ff;
  logic [7:0]                cnt_ff;
  logic                      armed_ff;
  logic                      tickFlag_ff, wdFlag_ff, stampFlag_ff, alarmFlag_ff, cdFlag_ff;
  logic                      irqPulse_ff;
  rtct_pkg::rtct_rp_t        rpState_ff;
  logic [rtct_pkg::RST_CNT_W-1:0] rpCnt_ff;
  logic                      wrFlags, rdFlags, wrCtl, wrVal, modeWr;
  logic                      srcTick, armTick, expireEvt, cdEvt, wdEvt, tickEvt;
  logic                      levelTerm, wdIrqTerm;

  function automatic logic pickTick(input rtct_pkg::rtct_src_t sel, input logic a,
                                    input logic b, input logic c, input logic d);
    case (sel)
      rtct_pkg::SRC_4K: pickTick = a;
      rtct_pkg::SRC_64: pickTick = b;
      rtct_pkg::SRC_1:  pickTick = c;
      default:          pickTick = d;
    endcase
  endfunction

  function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] ref_a);
    hit = stb && (a == ref_a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release and source clocks

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end

  assign sysRstN = rstSync2_ff;

  rtct_src_div #(
    .CLK_HZ (CLK_HZ)
  ) u_div (
    .mclk    (mclk),
    .sysRstN (sysRstN),
    .tick4k  (t4k),
    .tick64  (t64),
    .tick1   (t1),
    .tick60  (t60)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  always_comb begin
    wrFlags   = hit(regWr, regAddr, rtct_pkg::ADDR_FLAGS);
    rdFlags   = hit(regRd, regAddr, rtct_pkg::ADDR_FLAGS);
    wrCtl     = hit(regWr, regAddr, rtct_pkg::ADDR_TIMER_CTL);
    wrVal     = hit(regWr, regAddr, rtct_pkg::ADDR_TIMER_VAL);
    modeWr    = wrCtl && (regWrData[rtct_pkg::CTL_MODE_HI:rtct_pkg::CTL_MODE_LO] != mode_ff);
    srcTick   = pickTick(srcSel_ff, t4k, t64, t1, t60);
    armTick   = (srcSel_ff == rtct_pkg::SRC_4K) ? t4k : t64;
    expireEvt = (mode_ff != rtct_pkg::MODE_OFF) && armed_ff && srcTick
                && (cnt_ff == 8'h01) && !wrVal && !modeWr;
    cdEvt     = expireEvt && (mode_ff == rtct_pkg::MODE_CD);
    wdEvt     = expireEvt && mode_ff[1];
    tickEvt   = (secTickEn && t1) || (minTickEn && t60);
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      mode_ff     <= rtct_pkg::rtct_mode_t'(rtct_pkg::CTL_RESET[7:6]);
      pulseSel_ff <= rtct_pkg::CTL_RESET[5];
      srcSel_ff   <= rtct_pkg::rtct_src_t'(rtct_pkg::CTL_RESET[1:0]);
    end else if (wrCtl) begin
      mode_ff     <= rtct_pkg::rtct_mode_t'(regWrData[rtct_pkg::CTL_MODE_HI:rtct_pkg::CTL_MODE_LO]);
      pulseSel_ff <= regWrData[rtct_pkg::CTL_PULSE];
      srcSel_ff   <= rtct_pkg::rtct_src_t'(regWrData[rtct_pkg::CTL_SRC_HI:rtct_pkg::CTL_SRC_LO]);
    end
  end

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      nVal_ff <= rtct_pkg::BYTE_ZERO;
    end else if (wrVal) begin
      nVal_ff <= regWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // countdown / watchdog counter

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      cnt_ff   <= rtct_pkg::BYTE_ZERO;
      armed_ff <= 1'b0;
    end else if (wrVal) begin
      cnt_ff   <= regWrData;
      armed_ff <= 1'b0;
    end else if (modeWr) begin
      armed_ff <= 1'b0;
    end else if (mode_ff != rtct_pkg::MODE_OFF && cnt_ff != rtct_pkg::BYTE_ZERO) begin
      if (!armed_ff) begin
        armed_ff <= armTick;
      end else if (srcTick) begin
        if (cnt_ff == 8'h01) begin
          cnt_ff <= (mode_ff == rtct_pkg::MODE_CD) ? nVal_ff : rtct_pkg::BYTE_ZERO;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: set wins over clear

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      tickFlag_ff  <= 1'b0;
      cdFlag_ff    <= 1'b0;
      alarmFlag_ff <= 1'b0;
      stampFlag_ff <= 1'b0;
      wdFlag_ff    <= 1'b0;
    end else begin
      tickFlag_ff  <= tickEvt || (tickFlag_ff && !(wrFlags && !regWrData[rtct_pkg::FLG_TICK]));
      cdFlag_ff    <= cdEvt || (cdFlag_ff && !(wrFlags && !regWrData[rtct_pkg::FLG_CD]));
      alarmFlag_ff <= alarmEvt
                      || (alarmFlag_ff && !(wrFlags && !regWrData[rtct_pkg::FLG_ALARM]));
      stampFlag_ff <= stampGroundEvt
                      || (stampFlag_ff && !(wrFlags && !regWrData[rtct_pkg::FLG_STAMP]));
      wdFlag_ff    <= wdEvt || (wdFlag_ff && !rdFlags && !wrVal);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      regRdData <= rtct_pkg::BYTE_ZERO;
    end else if (regRd) begin
      case (regAddr)
        rtct_pkg::ADDR_FLAGS:     regRdData <= {tickFlag_ff, wdFlag_ff, stampFlag_ff,
                                               alarmFlag_ff, cdFlag_ff, 3'b000};
        rtct_pkg::ADDR_TIMER_CTL: regRdData <= {mode_ff, pulseSel_ff, 3'b000, srcSel_ff};
        rtct_pkg::ADDR_TIMER_VAL: regRdData <= cnt_ff;
        default:                  regRdData <= rtct_pkg::BYTE_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog reset pulse

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      rpState_ff <= rtct_pkg::RP_IDLE;
      rpCnt_ff   <= '0;
      rstOutN    <= 1'b1;
    end else begin
      case (rpState_ff)
        rtct_pkg::RP_IDLE: begin
          if (wdEvt && mode_ff == rtct_pkg::MODE_WD_RST) begin
            rpState_ff <= rtct_pkg::RP_HOLD;
            rstOutN    <= 1'b0;
            rpCnt_ff   <= (srcSel_ff == rtct_pkg::SRC_4K)
                          ? rtct_pkg::RST_CNT_W'(RST_SHORT_CYC - 1)
                          : rtct_pkg::RST_CNT_W'(RST_LONG_CYC - 1);
          end
        end
        rtct_pkg::RP_HOLD: begin
          if (wrVal || rpCnt_ff == '0) begin
            rpState_ff <= rtct_pkg::RP_IDLE;
            rstOutN    <= 1'b1;
          end else begin
            rpCnt_ff <= rpCnt_ff - 1'b1;
          end
        end
        default: begin
          rpState_ff <= rtct_pkg::RP_IDLE;
          rstOutN    <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output

  always_comb begin
    levelTerm = tickFlag_ff
                || (mode_ff == rtct_pkg::MODE_CD && cdFlag_ff && countdownIrqEn);
    wdIrqTerm = (mode_ff == rtct_pkg::MODE_WD_IRQ) && wdFlag_ff;
  end

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      irqPulse_ff <= 1'b0;
    end else if (tickEvt || (cdEvt && countdownIrqEn)) begin
      irqPulse_ff <= 1'b1;
    end else if (t64) begin
      irqPulse_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      irqN <= 1'b1;
    end else begin
      irqN <= !(wdIrqTerm || (pulseSel_ff ? irqPulse_ff : levelTerm));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!sysRstN);

  logic [rtct_pkg::RST_CNT_W-1:0] lowRun_ff;
  logic [rtct_pkg::RST_CNT_W-1:0] expW_ff;

  always_ff @(posedge mclk or negedge sysRstN) begin
    if (!sysRstN) begin
      lowRun_ff <= '0;
      expW_ff   <= '0;
    end else begin
      lowRun_ff <= rstOutN ? '0 : lowRun_ff + 1'b1;
      if (wdEvt && mode_ff == rtct_pkg::MODE_WD_RST && rpState_ff == rtct_pkg::RP_IDLE) begin
        expW_ff <= (srcSel_ff == rtct_pkg::SRC_4K) ? rtct_pkg::RST_CNT_W'(RST_SHORT_CYC)
                                                   : rtct_pkg::RST_CNT_W'(RST_LONG_CYC);
      end
    end
  end

  sequence seqDecStep;
    armed_ff && srcTick && cnt_ff > 8'h01 && mode_ff != rtct_pkg::MODE_OFF && !wrVal && !modeWr;
  endsequence

  sequence seqCdExpire;
    cdEvt;
  endsequence

  AST_RST_WIDTH: assert property ($rose(rstOutN) && !$past(wrVal) |-> lowRun_ff == expW_ff)
    else $error("reset pulse width wrong");
  AST_DEC_STEP: assert property (seqDecStep |=> cnt_ff == $past(cnt_ff) - 8'h01)
    else $error("counter did not step down by one");
  AST_CD_RELOAD: assert property (seqCdExpire |=> cnt_ff == $past(nVal_ff) && cdFlag_ff)
    else $error("countdown did not reload or flag");
  AST_ZERO_HALT: assert property (cnt_ff == 8'h00 && !wrVal |=> cnt_ff == 8'h00)
    else $error("counter moved while halted");
  AST_READ_LIVE: assert property (hit(regRd, regAddr, rtct_pkg::ADDR_TIMER_VAL)
                                  |=> regRdData == $past(cnt_ff))
    else $error("timer read not live counter");
  AST_WRITE_NOW: assert property (wrVal |=> cnt_ff == $past(regWrData) && nVal_ff == cnt_ff)
    else $error("start value not applied at once");
  AST_FLAG_KEEP: assert property (cdFlag_ff && !(wrFlags && !regWrData[rtct_pkg::FLG_CD])
                                  |=> cdFlag_ff)
    else $error("countdown flag lost without clear");
  AST_AND_CLEAR: assert property (wrFlags && !regWrData[rtct_pkg::FLG_CD] && !cdEvt
                                  |=> !cdFlag_ff)
    else $error("flag not cleared by zero write");
  AST_IRQ_LEVEL: assert property (!pulseSel_ff && mode_ff == rtct_pkg::MODE_CD && cdFlag_ff
                                  && countdownIrqEn |=> !irqN)
    else $error("level interrupt missing");
  AST_IRQ_RELEASE: assert property (!pulseSel_ff && mode_ff == rtct_pkg::MODE_CD && !cdFlag_ff
                                    && !tickFlag_ff |=> irqN)
    else $error("interrupt held after clear");
  AST_TICK_SET: assert property (secTickEn && t1 |=> tickFlag_ff)
    else $error("second tick not flagged");

endmodule

`default_nettype wire

// ===== rtct_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module rtct_host_model (
  // register port toward the timer block
  input  wire logic       mclk,
  output logic      [7:0] regAddr,
  output logic            regWr,
  output logic            regRd,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    #1;
    d = regRdData;
  endtask

  // live counter read, repeated until two reads agree, five reads at most
  task automatic rd2(output logic [7:0] d);
    logic [7:0] prev;
    rd(rtct_pkg::ADDR_TIMER_VAL, prev);
    for (int i = 0; i < 4; i++) begin
      rd(rtct_pkg::ADDR_TIMER_VAL, d);
      if (d === prev) break;
      prev = d;
    end
  endtask

  // clear flags in mask: watchdog bit and low bits written as zero
  task automatic clr(input logic [7:0] m);
    wr(rtct_pkg::ADDR_FLAGS, 8'hB8 & ~m);
  endtask

  // timer off before a new start value, then the wanted control
  task automatic load(input logic [7:0] ctl, input logic [7:0] n);
    wr(rtct_pkg::ADDR_TIMER_CTL, rtct_pkg::BYTE_ZERO);
    wr(rtct_pkg::ADDR_TIMER_VAL, n);
    wr(rtct_pkg::ADDR_TIMER_CTL, ctl);
  endtask
endmodule

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int unsigned RST_S = 5;
  localparam int unsigned RST_L = 20;
  localparam int unsigned LIMIT = 30000;

  logic       mclk;
  logic       rst_n;
  logic [7:0] regAddr;
  logic       regWr;
  logic       regRd;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic       alarmEvt;
  logic       stampGroundEvt;
  logic       secTickEn;
  logic       minTickEn;
  logic       countdownIrqEn;
  logic       irqN;
  logic       rstOutN;
  int         fails;
  int         tests_run;
  int         cyc;
  logic [7:0] v;
  int         n;
  int         a;

  rtct_timer_flags #(.CLK_HZ(8192), .RST_SHORT_CYC(RST_S), .RST_LONG_CYC(RST_L))
    i_rtct_timer_flags (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData), .alarmEvt(alarmEvt),
    .stampGroundEvt(stampGroundEvt), .secTickEn(secTickEn), .minTickEn(minTickEn),
    .countdownIrqEn(countdownIrqEn), .irqN(irqN), .rstOutN(rstOutN));

  rtct_host_model i_rtct_host_model (
    .mclk(mclk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
    .regWrData(regWrData), .regRdData(regRdData));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // cycles until irqN (sel 0) or rstOutN (sel 1) reaches lvl
  task automatic wait_lvl(input int sel, input logic lvl, input int lim, output int c);
    c = 0;
    while (((sel == 0) ? irqN : rstOutN) !== lvl && c < lim) begin
      @(posedge mclk);
      #1;
      c++;
    end
    check({7'h00, c < lim}, 8'h01);
  endtask

  task automatic end_sim();
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      end_sim();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] codes [5] = '{8'h00, 8'h41, 8'hA2, 8'hE3, 8'h1C};
    fails = 0;
    tests_run = 0;
    cyc = 0;
    rst_n = 1'b0;
    alarmEvt = 1'b0;
    stampGroundEvt = 1'b0;
    secTickEn = 1'b0;
    minTickEn = 1'b0;
    countdownIrqEn = 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // reset values and an unmapped address
    i_rtct_host_model.rd(rtct_pkg::ADDR_TIMER_CTL, v);
    check(v, 8'h03);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h00);
    i_rtct_host_model.rd(8'h55, v);
    check(v, 8'h00);
    // every mode and source code, unused bits read zero
    foreach (codes[i]) begin
      i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_CTL, codes[i]);
      i_rtct_host_model.rd(rtct_pkg::ADDR_TIMER_CTL, v);
      check(v, codes[i] & 8'hE3);
    end
    // first countdown period, level interrupt
    countdownIrqEn <= 1'b1;
    i_rtct_host_model.load(8'h40, 8'h03);
    wait_lvl(0, 1'b0, 50, n);
    check({7'h00, n >= 5 && n <= 12}, 8'h01);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h08);
    check({7'h00, irqN}, 8'h00);
    // new start value on the fly, then AND clearing
    i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_VAL, 8'h64);
    @(posedge mclk);
    alarmEvt <= 1'b1;
    stampGroundEvt <= 1'b1;
    @(posedge mclk);
    alarmEvt <= 1'b0;
    stampGroundEvt <= 1'b0;
    i_rtct_host_model.clr(8'h08);
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, irqN}, 8'h01);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h30);
    i_rtct_host_model.clr(8'h08);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h30);
    i_rtct_host_model.rd2(v);
    check({7'h00, v < 8'h64 && v > 8'h46}, 8'h01);
    i_rtct_host_model.clr(8'h30);
    // interrupt disabled while the flag sets
    countdownIrqEn <= 1'b0;
    a = 0;
    repeat (220) begin
      @(posedge mclk);
      #1;
      a += (irqN === 1'b0);
    end
    check(a[7:0], 8'h00);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h08);
    // pulsed interrupt, one per period of 100 ticks
    countdownIrqEn <= 1'b1;
    i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_CTL, 8'h60);
    wait_lvl(0, 1'b1, 300, n);
    wait_lvl(0, 1'b0, 300, n);
    wait_lvl(0, 1'b1, 300, a);
    wait_lvl(0, 1'b0, 300, n);
    check(8'(a + n), 8'hC8);
    // zero start value halts
    i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_VAL, 8'h00);
    i_rtct_host_model.clr(8'h08);
    repeat (250) @(posedge mclk);
    i_rtct_host_model.rd2(v);
    check(v, 8'h00);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h00);
    // watchdog reset width on fast and slow source
    for (int s = 0; s < 2; s++) begin
      i_rtct_host_model.load(8'hC0 | 8'(s), 8'h02);
      wait_lvl(1, 1'b0, 600, n);
      wait_lvl(1, 1'b1, 100, a);
      check(8'(a), (s == 0) ? 8'(RST_S) : 8'(RST_L));
      i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
      check(v, 8'h40);
      i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
      check(v, 8'h00);
    end
    // watchdog to interrupt, released by a value write
    i_rtct_host_model.load(8'h80, 8'h01);
    wait_lvl(0, 1'b0, 50, n);
    check({7'h00, rstOutN}, 8'h01);
    i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_VAL, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, irqN}, 8'h01);
    // second tick with both timers off
    i_rtct_host_model.wr(rtct_pkg::ADDR_TIMER_CTL, 8'h00);
    secTickEn <= 1'b1;
    minTickEn <= 1'b1;
    wait_lvl(0, 1'b0, 9000, n);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h80);
    secTickEn <= 1'b0;
    minTickEn <= 1'b0;
    i_rtct_host_model.clr(8'h80);
    i_rtct_host_model.rd(rtct_pkg::ADDR_FLAGS, v);
    check(v, 8'h00);
    end_sim();
  end
endmodule

`default_nettype wire
